// file: hw/debug_command_register_access.sv
// Purpose: debug TAP command word decode and debug register access
// Assumes: tck, tms, tdi and tap select arrive unsynchronised
// Notes: tck is oversampled by ref_clk, tck must be below ref_clk / 8
//
// Notes on behaviour
// - exit honoured only with execute, scan/no-register
// - exit happens on entry to Update-DR
// - pending request, or status with enable set, re-enters debug
// - bits 0 to 6 select the register
// - writes to read-only registers are dropped
// - gated registers need external debug enable
// - before enable, control zero write touches enable only
// - enable bit blocks software debug register updates
// - 0010000 scan chain, 0010001 no register
// - 0010010 entry control, 0000010 identification
// - 0100000-0100111 address and value comparators
// - 0101100 counter, 0101101 program counter history
// - 0110000 status, 0110001-0110011 control registers
// - 1110000-1111001 general, 1111100 nexus, 1111110 emulation, 1111111 bypass
// - 1111010 cache control, 1111011 cache data
// - write: command with direction clear, then data
// - read: command with direction set, data out
// - all scans shift least significant bit first
// - control zero resets zero, enable is bit 31
// - bit 9 direction, ignored for fixed registers
// - execute runs the scan chain instruction
// - ten-bit command loads on Update-IR entry
// - command resets on deselect, reset, Test-Logic-Reset
`timescale 1ns/1ps
`default_nettype none

module debug_command_register_access #(
  parameter logic [31:0] id_code = 32'h0A5C_3001 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tap_select_line,
  input wire logic [31:0] pc_history,
  input wire logic [31:0] status_events,
  output logic tdo,
  output logic tdo_en,
  output logic debug_mode,
  output logic step_pulse,
  output logic resume_pulse,
  output logic [31:0] exec_instr,
  output logic [31:0] debug_control_zero,
  output logic sw_update_block,
  output logic nexus_path_sel,
  output logic emul_enable_sel
);

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  logic [3:0] pin_level, pin_rise, pin_fall;
  dbg_cmd_pkg::pins_s pins;
  logic tck_rise, tck_fall;

  pin_sampler #(.WIDTH(4)) u_pins (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in({tck, tms, tdi, tap_select_line}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // tck edges taken from the filtered level
  assign pins = pin_level;
  assign tck_rise = pin_rise[3];
  assign tck_fall = pin_fall[3];

  // ------------------------------------------------------------
  // scan path state
  // ------------------------------------------------------------
  dbg_cmd_pkg::tap_state_e tap_state, next_tap_state, tap_move;
  dbg_cmd_pkg::cmd_s cmd, next_cmd;
  logic [9:0] ir_sr, next_ir_sr;
  logic [31:0] dr_sr, next_dr_sr;
  logic next_tdo, next_tdo_en;
  dbg_cmd_pkg::acc_s acc;
  logic [31:0] regs [dbg_cmd_pkg::NUM_SLOTS];
  logic external_debug_enable;
  logic [31:0] read_value;
  logic upd_dr;

  assign acc = dbg_cmd_pkg::decode(cmd.rs);
  assign external_debug_enable = regs[dbg_cmd_pkg::SLOT_DEBUG_CONTROL_ZERO][dbg_cmd_pkg::EDM_BIT];

  // ------------------------------------------------------------
  // tap controller
  // ------------------------------------------------------------

  // tap controller transition on tms
  always_comb begin
    case (tap_state)
      dbg_cmd_pkg::TLR: tap_move = pins.tms ? dbg_cmd_pkg::TLR : dbg_cmd_pkg::IDLE;
      dbg_cmd_pkg::IDLE: tap_move = pins.tms ? dbg_cmd_pkg::SEL_DR : dbg_cmd_pkg::IDLE;
      dbg_cmd_pkg::SEL_DR: tap_move = pins.tms ? dbg_cmd_pkg::SEL_IR : dbg_cmd_pkg::CAP_DR;
      dbg_cmd_pkg::CAP_DR: tap_move = pins.tms ? dbg_cmd_pkg::EXIT1_DR : dbg_cmd_pkg::SHIFT_DR;
      dbg_cmd_pkg::SHIFT_DR: tap_move = pins.tms ? dbg_cmd_pkg::EXIT1_DR : dbg_cmd_pkg::SHIFT_DR;
      dbg_cmd_pkg::EXIT1_DR: tap_move = pins.tms ? dbg_cmd_pkg::UPD_DR : dbg_cmd_pkg::PAUSE_DR;
      dbg_cmd_pkg::PAUSE_DR: tap_move = pins.tms ? dbg_cmd_pkg::EXIT2_DR : dbg_cmd_pkg::PAUSE_DR;
      dbg_cmd_pkg::EXIT2_DR: tap_move = pins.tms ? dbg_cmd_pkg::UPD_DR : dbg_cmd_pkg::SHIFT_DR;
      dbg_cmd_pkg::UPD_DR: tap_move = pins.tms ? dbg_cmd_pkg::SEL_DR : dbg_cmd_pkg::IDLE;
      dbg_cmd_pkg::SEL_IR: tap_move = pins.tms ? dbg_cmd_pkg::TLR : dbg_cmd_pkg::CAP_IR;
      dbg_cmd_pkg::CAP_IR: tap_move = pins.tms ? dbg_cmd_pkg::EXIT1_IR : dbg_cmd_pkg::SHIFT_IR;
      dbg_cmd_pkg::SHIFT_IR: tap_move = pins.tms ? dbg_cmd_pkg::EXIT1_IR : dbg_cmd_pkg::SHIFT_IR;
      dbg_cmd_pkg::EXIT1_IR: tap_move = pins.tms ? dbg_cmd_pkg::UPD_IR : dbg_cmd_pkg::PAUSE_IR;
      dbg_cmd_pkg::PAUSE_IR: tap_move = pins.tms ? dbg_cmd_pkg::EXIT2_IR : dbg_cmd_pkg::PAUSE_IR;
      dbg_cmd_pkg::EXIT2_IR: tap_move = pins.tms ? dbg_cmd_pkg::UPD_IR : dbg_cmd_pkg::SHIFT_IR;
      dbg_cmd_pkg::UPD_IR: tap_move = pins.tms ? dbg_cmd_pkg::SEL_DR : dbg_cmd_pkg::IDLE;
      default: tap_move = dbg_cmd_pkg::TLR;
    endcase
  end

  // ------------------------------------------------------------
  // capture source
  // ------------------------------------------------------------

  // value presented to the data scan on capture
  always_comb begin
    case (acc.src)
      dbg_cmd_pkg::SRC_ID: read_value = id_code;
      dbg_cmd_pkg::SRC_PCH: read_value = pc_history;
      dbg_cmd_pkg::SRC_STORE: read_value = (acc.gated && !external_debug_enable &&
                                            acc.slot != dbg_cmd_pkg::SLOT_DEBUG_CONTROL_ZERO)
                                           ? 32'h0000_0000 : regs[acc.slot];
      default: read_value = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // scan path next values
  // ------------------------------------------------------------

  // scan path next values: state, command, shift registers, tdo
  always_comb begin
    next_tap_state = tap_state;
    next_cmd = cmd;
    next_ir_sr = ir_sr;
    next_dr_sr = dr_sr;
    next_tdo = tdo;
    next_tdo_en = tdo_en;
    upd_dr = 1'b0;
    if (!pins.sel) begin
      next_tap_state = dbg_cmd_pkg::TLR;
      next_cmd = dbg_cmd_pkg::CMD_RESET;
    end else if (tck_rise) begin
      next_tap_state = tap_move;
      case (tap_state)
        dbg_cmd_pkg::CAP_IR: next_ir_sr = dbg_cmd_pkg::IR_CAPTURE;
        dbg_cmd_pkg::SHIFT_IR: next_ir_sr = {pins.tdi, ir_sr[9:1]};
        dbg_cmd_pkg::CAP_DR: next_dr_sr = (acc.src == dbg_cmd_pkg::SRC_NONE)
                                          ? 32'h0000_0000 : read_value;
        dbg_cmd_pkg::SHIFT_DR: begin
          if (acc.src == dbg_cmd_pkg::SRC_NONE) begin
            next_dr_sr = {31'h0000_0000, pins.tdi};
          end else begin
            next_dr_sr = {pins.tdi, dr_sr[31:1]};
          end
        end
        default: begin
        end
      endcase
      if (tap_move == dbg_cmd_pkg::UPD_IR) begin
        next_cmd = ir_sr;
      end
      if (tap_move == dbg_cmd_pkg::UPD_DR) begin
        upd_dr = 1'b1;
      end
      if (tap_move == dbg_cmd_pkg::TLR) begin
        next_cmd = dbg_cmd_pkg::CMD_RESET;
      end
    end else if (tck_fall) begin
      next_tdo_en = 1'b0;
      if (tap_state == dbg_cmd_pkg::SHIFT_IR) begin
        next_tdo = ir_sr[0];
        next_tdo_en = 1'b1;
      end else if (tap_state == dbg_cmd_pkg::SHIFT_DR) begin
        next_tdo = dr_sr[0];
        next_tdo_en = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // scan path storage
  // ------------------------------------------------------------

  // scan path registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_state <= dbg_cmd_pkg::TLR;
      cmd <= dbg_cmd_pkg::CMD_RESET;
      ir_sr <= 10'h000;
      dr_sr <= 32'h0000_0000;
      tdo <= 1'b0;
      tdo_en <= 1'b0;
    end else if (ce) begin
      tap_state <= next_tap_state;
      cmd <= next_cmd;
      ir_sr <= next_ir_sr;
      dr_sr <= next_dr_sr;
      tdo <= next_tdo;
      tdo_en <= next_tdo_en;
    end
  end

  // ------------------------------------------------------------
  // debug registers and run control
  // ------------------------------------------------------------
  logic [31:0] next_regs [dbg_cmd_pkg::NUM_SLOTS];
  logic next_debug_mode, next_step_pulse, next_resume_pulse;
  logic go_sel, do_write;

  // execute and exit only apply to scan chain or no-register selects
  assign go_sel = (cmd.rs == dbg_cmd_pkg::RS_SCAN) ||
                  (cmd.rs == dbg_cmd_pkg::RS_NOREG);
  assign do_write = upd_dr && !cmd.rd_n_wr && acc.src == dbg_cmd_pkg::SRC_STORE &&
                    acc.wr;

  // ------------------------------------------------------------
  // run control next values
  // ------------------------------------------------------------

  // register writes, status set and clear, debug mode sequencing
  always_comb begin
    next_regs = regs;
    next_debug_mode = debug_mode;
    next_step_pulse = 1'b0;
    next_resume_pulse = 1'b0;
    if (do_write) begin
      if (acc.slot == dbg_cmd_pkg::SLOT_DEBUG_CONTROL_ZERO && !external_debug_enable) begin
        next_regs[acc.slot][dbg_cmd_pkg::EDM_BIT] = dr_sr[dbg_cmd_pkg::EDM_BIT];
      end else if (acc.gated && !external_debug_enable) begin
        next_regs[acc.slot] = regs[acc.slot];
      end else if (acc.clr_on_one) begin
        next_regs[acc.slot] = regs[acc.slot] & ~dr_sr;
      end else begin
        next_regs[acc.slot] = dr_sr;
      end
    end
    // status events set over a same-cycle clear
    next_regs[dbg_cmd_pkg::SLOT_STATUS] = next_regs[dbg_cmd_pkg::SLOT_STATUS] | status_events;
    if (upd_dr && cmd.go && go_sel) begin
      if (cmd.ex) begin
        next_debug_mode = 1'b0;
        next_resume_pulse = 1'b1;
      end else begin
        next_step_pulse = 1'b1;
      end
    end else if (!debug_mode &&
                 (regs[dbg_cmd_pkg::SLOT_ENTRY][dbg_cmd_pkg::ENTRY_REQ_BIT] ||
                  (external_debug_enable && regs[dbg_cmd_pkg::SLOT_STATUS] != 32'h0000_0000))) begin
      next_debug_mode = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // register file storage
  // ------------------------------------------------------------

  // register file and run control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dbg_cmd_pkg::NUM_SLOTS; i++) begin
        regs[i] <= dbg_cmd_pkg::CTRL_RESET;
      end
      debug_mode <= 1'b0;
      step_pulse <= 1'b0;
      resume_pulse <= 1'b0;
    end else if (ce) begin
      regs <= next_regs;
      debug_mode <= next_debug_mode;
      step_pulse <= next_step_pulse;
      resume_pulse <= next_resume_pulse;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // instruction field and control zero shown to the processor
  assign exec_instr = regs[dbg_cmd_pkg::SLOT_SCAN];
  assign debug_control_zero = regs[dbg_cmd_pkg::SLOT_DEBUG_CONTROL_ZERO];
  assign sw_update_block = external_debug_enable;
  // auxiliary path selects are bypass-length here
  assign nexus_path_sel = (cmd.rs == dbg_cmd_pkg::RS_NEXUS);
  assign emul_enable_sel = (cmd.rs == dbg_cmd_pkg::RS_EMUL);

endmodule

`default_nettype wire

// file: hw/dbg_cmd_pkg.sv
// Purpose: shared constants and types of the debug command register block
// Assumes: command word and data shift least significant bit first
// Notes: command bit 9 is the direction flag, bit 8 execute, bit 7 exit
package dbg_cmd_pkg;

  // --------------------------------------------------------------
  // widths and reset values
  // --------------------------------------------------------------
  localparam int CMD_W = 10;
  localparam int DATA_W = 32;
  localparam int NUM_SLOTS = 27;
  localparam logic [9:0] CMD_RESET = 10'h202;
  localparam logic [9:0] IR_CAPTURE = 10'h001;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int EDM_BIT = 31;
  localparam int ENTRY_REQ_BIT = 0;

  // --------------------------------------------------------------
  // register select codes
  // --------------------------------------------------------------
  localparam logic [6:0] RS_ID = 7'h02;
  localparam logic [6:0] RS_SCAN = 7'h10;
  localparam logic [6:0] RS_NOREG = 7'h11;
  localparam logic [6:0] RS_ENTRY = 7'h12;
  localparam logic [6:0] RS_IAC0 = 7'h20;
  localparam logic [6:0] RS_DATA_VALUE_COMPARE = 7'h27;
  localparam logic [6:0] RS_CNT = 7'h2C;
  localparam logic [6:0] RS_PCH = 7'h2D;
  localparam logic [6:0] RS_STATUS = 7'h30;
  localparam logic [6:0] RS_DEBUG_CONTROL_ZERO = 7'h31;
  localparam logic [6:0] RS_DBCR2 = 7'h33;
  localparam logic [6:0] RS_GP0 = 7'h70;
  localparam logic [6:0] RS_GP9 = 7'h79;
  localparam logic [6:0] RS_CACHE_CTL = 7'h7A;
  localparam logic [6:0] RS_CACHE_DATA = 7'h7B;
  localparam logic [6:0] RS_NEXUS = 7'h7C;
  localparam logic [6:0] RS_EMUL = 7'h7E;
  localparam logic [6:0] RS_BYPASS = 7'h7F;

  // --------------------------------------------------------------
  // storage slots
  // --------------------------------------------------------------
  localparam logic [4:0] SLOT_SCAN = 5'h00;
  localparam logic [4:0] SLOT_ENTRY = 5'h01;
  localparam logic [4:0] SLOT_IAC0 = 5'h02;
  localparam logic [4:0] SLOT_CNT = 5'h0A;
  localparam logic [4:0] SLOT_STATUS = 5'h0B;
  localparam logic [4:0] SLOT_DEBUG_CONTROL_ZERO = 5'h0C;
  localparam logic [4:0] SLOT_CACHE_CTL = 5'h0F;
  localparam logic [4:0] SLOT_GP0 = 5'h11;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR = 4'h0, IDLE = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SHIFT_DR = 4'h4, EXIT1_DR = 4'h5, PAUSE_DR = 4'h6, EXIT2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SHIFT_IR = 4'hB,
    EXIT1_IR = 4'hC, PAUSE_IR = 4'hD, EXIT2_IR = 4'hE, UPD_IR = 4'hF
  } tap_state_e;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_STORE = 2'h1,
    SRC_ID = 2'h2,
    SRC_PCH = 2'h3
  } src_e;

  typedef struct packed {
    logic rd_n_wr;
    logic go;
    logic ex;
    logic [6:0] rs;
  } cmd_s;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic sel;
  } pins_s;

  typedef struct packed {
    src_e src;
    logic [4:0] slot;
    logic wr;
    logic gated;
    logic clr_on_one;
  } acc_s;

  // select code to storage path and access attributes
  function automatic acc_s decode(input logic [6:0] rs);
    acc_s a;
    a = '{src: SRC_NONE, slot: 5'h00, wr: 1'b0, gated: 1'b0, clr_on_one: 1'b0};
    if (rs == RS_ID) begin
      a.src = SRC_ID;
    end else if (rs == RS_SCAN) begin
      a = '{src: SRC_STORE, slot: SLOT_SCAN, wr: 1'b1, gated: 1'b1, clr_on_one: 1'b0};
    end else if (rs == RS_ENTRY) begin
      a = '{src: SRC_STORE, slot: SLOT_ENTRY, wr: 1'b1, gated: 1'b0, clr_on_one: 1'b0};
    end else if (rs >= RS_IAC0 && rs <= RS_DATA_VALUE_COMPARE) begin
      a = '{src: SRC_STORE, slot: 5'(SLOT_IAC0 + {2'h0, rs[2:0]}), wr: 1'b1,
            gated: 1'b1, clr_on_one: 1'b0};
    end else if (rs == RS_CNT) begin
      a = '{src: SRC_STORE, slot: SLOT_CNT, wr: 1'b1, gated: 1'b1, clr_on_one: 1'b0};
    end else if (rs == RS_PCH) begin
      a.src = SRC_PCH;
    end else if (rs == RS_STATUS) begin
      a = '{src: SRC_STORE, slot: SLOT_STATUS, wr: 1'b1, gated: 1'b1, clr_on_one: 1'b1};
    end else if (rs >= RS_DEBUG_CONTROL_ZERO && rs <= RS_DBCR2) begin
      a = '{src: SRC_STORE, slot: 5'(SLOT_DEBUG_CONTROL_ZERO + {3'h0, rs[1:0]} - 5'h01), wr: 1'b1,
            gated: 1'b1, clr_on_one: 1'b0};
    end else if (rs >= RS_GP0 && rs <= RS_GP9) begin
      a = '{src: SRC_STORE, slot: 5'(SLOT_GP0 + {1'h0, rs[3:0]}), wr: 1'b1,
            gated: 1'b0, clr_on_one: 1'b0};
    end else if (rs == RS_CACHE_CTL || rs == RS_CACHE_DATA) begin
      a = '{src: SRC_STORE, slot: 5'(SLOT_CACHE_CTL + {4'h0, rs[0]}), wr: 1'b1,
            gated: 1'b0, clr_on_one: 1'b0};
    end
    return a;
  endfunction

endpackage

// file: hw/pin_sampler.sv
// Purpose: three-stage sampler for pins from outside the clock domain
// Assumes: level moves only when the second and third stages agree
// Notes: rise and fall are one-cycle pulses on the filtered level
`timescale 1ns/1ps
`default_nettype none

module pin_sampler #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] s1, s2, s3;
  logic [WIDTH-1:0] next_s1, next_s2, next_s3, next_level, next_rise, next_fall;

  // shift stages, filter on agreement of stages two and three
  always_comb begin
    next_s1 = async_in;
    next_s2 = s1;
    next_s3 = s2;
    next_level = (s2 & s3) | (level & (s2 | s3));
    next_rise = next_level & ~level;
    next_fall = ~next_level & level;
  end

  // registers frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
      rise <= '0;
      fall <= '0;
    end else if (ce) begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

endmodule

`default_nettype wire

// file: verification/dbg_cmd_sva.sv
// Purpose: port assertions for the debug command block
// Assumes: tck pin is slow against ref_clk, idles low
// Notes: bound to the design from the testbench file
`timescale 1ns/1ps
`default_nettype none

module dbg_cmd_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tap_select_line,
  input wire logic tdo,
  input wire logic tdo_en,
  input wire logic debug_mode,
  input wire logic step_pulse,
  input wire logic resume_pulse,
  input wire logic [31:0] debug_control_zero,
  input wire logic sw_update_block,
  input wire logic nexus_path_sel,
  input wire logic emul_enable_sel
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_resume;
    resume_pulse |-> !debug_mode && tck;
  endproperty
  a_resume: assert property (p_resume) else $error("resume kept debug");
  property p_resume_one;
    resume_pulse |=> !resume_pulse;
  endproperty
  a_resume_one: assert property (p_resume_one) else $error("resume too long");
  property p_step;
    step_pulse |-> tck && !resume_pulse ##1 !step_pulse;
  endproperty
  a_step: assert property (p_step) else $error("bad step pulse");
  property p_block;
    sw_update_block == debug_control_zero[dbg_cmd_pkg::EDM_BIT];
  endproperty
  a_block: assert property (p_block) else $error("block differs");
  property p_sel;
    !(nexus_path_sel && emul_enable_sel);
  endproperty
  a_sel: assert property (p_sel) else $error("two selects");
  property p_tap_off;
    (!tap_select_line) [*8] |-> !tdo_en && !nexus_path_sel && !emul_enable_sel;
  endproperty
  a_tap_off: assert property (p_tap_off) else $error("tap not reset");
  property p_tdo;
    $changed(tdo) || $changed(tdo_en) |-> !tck;
  endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved on rise");
  property p_ctrl_upd;
    $changed(debug_control_zero) |-> tck;
  endproperty
  a_ctrl_upd: assert property (p_ctrl_upd) else $error("control moved");
  property p_edm_only;
    $changed(debug_control_zero) && !$past(debug_control_zero[31])
      |-> debug_control_zero[30:0] == $past(debug_control_zero[30:0]);
  endproperty
  a_edm_only: assert property (p_edm_only) else $error("low bits written");
endmodule

`default_nettype wire

// file: verification/jtag_tool.sv
// Purpose: behavioural debug tool driving the scan pins
// Assumes: tck period 125 ns, pins move on ref_clk falling edge
// Notes: tck stands low between frames, tdi idles inverted
`timescale 1ns/1ps
`default_nettype none

module jtag_tool (
  input wire logic ref_clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic got,
  output logic [31:0] got_data
);
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    got = 1'b0;
    got_data = 32'h0;
  end

  // one tck period, tdo taken just before the rise
  task automatic tick(input logic m, input logic d, output logic so);
    tms = m;
    tdi = d;
    repeat (13) @(negedge ref_clk);
    so = tdo;
    tck = 1'b1;
    repeat (12) @(negedge ref_clk);
    tck = 1'b0;
  endtask

  // one frame from idle back to idle, lsb first
  task automatic scan(input bit ir, input int n, input logic [31:0] din, input bit rd);
    logic so;
    logic [31:0] dout;
    dout = 32'h0;
    @(negedge ref_clk);
    tick(1'b0, ~tdi, so);
    tick(1'b1, ~tdi, so);
    if (ir) tick(1'b1, ~tdi, so);
    tick(1'b0, ~tdi, so);
    tick(1'b0, ~tdi, so);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], so);
      dout[i] = so;
    end
    tick(1'b1, ~tdi, so);
    tick(1'b0, ~tdi, so);
    tdi = ~tdi;
    if (rd) begin
      got_data = dout;
      got = 1'b1;
      @(negedge ref_clk);
      got = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// file: verification/testbench.sv
// Purpose: self-checking bench for the debug command block
// Assumes: tool model drives the scan pins, bench the rest
// Notes: expected read values go through a queue to the monitor
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [31:0] ID_VAL = 32'h1357_9BDF; // arbitrary value
  localparam logic [6:0] SELS [11] = '{dbg_cmd_pkg::RS_IAC0, 7'h23, 7'h24,
    dbg_cmd_pkg::RS_DATA_VALUE_COMPARE, dbg_cmd_pkg::RS_CNT, 7'h32, dbg_cmd_pkg::RS_DBCR2,
    dbg_cmd_pkg::RS_GP0, dbg_cmd_pkg::RS_GP9, dbg_cmd_pkg::RS_CACHE_CTL,
    dbg_cmd_pkg::RS_CACHE_DATA};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic tap_select_line = 1'b1;
  logic [31:0] pc_history = 32'h0;
  logic [31:0] status_events = 32'h0;
  logic tck, tms, tdi, tdo, tdo_en, debug_mode, step_pulse, resume_pulse;
  logic sw_update_block, nexus_path_sel, emul_enable_sel, got;
  logic [31:0] exec_instr, debug_control_zero, got_data, v;
  logic [31:0] q[$];
  int seed = 83;
  int n_fail = 0;
  int n_checks = 0;
  int n_resume = 0;
  int n_step = 0;

  always #2.5 ref_clk = ~ref_clk;

  debug_command_register_access #(.id_code(ID_VAL)) debug_command_register_access_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
    .tap_select_line(tap_select_line), .pc_history(pc_history),
    .status_events(status_events), .tdo(tdo), .tdo_en(tdo_en), .debug_mode(debug_mode),
    .step_pulse(step_pulse), .resume_pulse(resume_pulse), .exec_instr(exec_instr),
    .debug_control_zero(debug_control_zero), .sw_update_block(sw_update_block),
    .nexus_path_sel(nexus_path_sel), .emul_enable_sel(emul_enable_sel));
  jtag_tool jtag_tool_i (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
    .got(got), .got_data(got_data));

  // ----------------------------------------
  // checking and scan helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic ir(input logic [9:0] c);
    jtag_tool_i.scan(1'b1, 10, {22'h0, c}, 1'b0);
  endtask

  task automatic wr(input logic [9:0] c, input logic [31:0] d);
    ir(c);
    jtag_tool_i.scan(1'b0, 32, d, 1'b0);
  endtask

  task automatic rd(input logic [9:0] c, input int n, input logic [31:0] exp);
    q.push_back(exp);
    ir(c);
    jtag_tool_i.scan(1'b0, n, $random(seed), 1'b1);
  endtask

  // read results against notes, pulse counting
  always @(posedge ref_clk) begin
    if (got) check(got_data, q.pop_front());
    if (resume_pulse === 1'b1) n_resume++;
    if (step_pulse === 1'b1) n_step++;
  end

  // watchdog
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    print_verdict;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    pc_history = $random(seed);
    q.push_back(ID_VAL);
    jtag_tool_i.scan(1'b0, 32, $random(seed), 1'b1);
    wr(10'h002, $random(seed));
    rd(10'h202, 32, ID_VAL);
    wr(10'h02C, $random(seed));
    rd(10'h22C, 32, 32'h0);
    wr({3'b000, dbg_cmd_pkg::RS_ENTRY}, 32'h1);
    wr(10'h031, 32'hFFFF_FFFF);
    check(debug_control_zero, 32'h8000_0000);
    check({31'h0, tdo_en}, 32'h0);
    check({31'h0, sw_update_block}, 32'h1);
    rd(10'h231, 32, 32'h8000_0000);
    foreach (SELS[i]) begin
      v = $random(seed);
      wr({3'b000, SELS[i]}, v);
      rd({3'b100, SELS[i]}, 32, v);
    end
    rd({3'b100, dbg_cmd_pkg::RS_PCH}, 32, pc_history);
    rd(10'h213, 1, 32'h0);
    ir(10'h27C);
    check({nexus_path_sel, emul_enable_sel}, 32'h2);
    ir(10'h27E);
    check({nexus_path_sel, emul_enable_sel}, 32'h1);
    wr({3'b000, dbg_cmd_pkg::RS_ENTRY}, 32'h1);
    check({31'h0, debug_mode}, 32'h1);
    v = $random(seed);
    wr(10'h190, v);
    check(exec_instr, v);
    check(n_resume, 32'h1);
    check({31'h0, debug_mode}, 32'h1);
    wr({3'b000, dbg_cmd_pkg::RS_ENTRY}, 32'h0);
    wr(10'h110, $random(seed));
    check(n_step, 32'h1);
    wr(10'h1AC, $random(seed));
    check(n_resume + n_step, 32'h2);
    ir(10'h191);
    jtag_tool_i.scan(1'b0, 1, $random(seed), 1'b0);
    check(n_resume, 32'h2);
    check({31'h0, debug_mode}, 32'h0);
    status_events = 32'h1;
    @(negedge ref_clk);
    status_events = 32'h0;
    repeat (4) @(negedge ref_clk);
    check({31'h0, debug_mode}, 32'h1);
    tap_select_line = 1'b0;
    repeat (20) @(negedge ref_clk);
    tap_select_line = 1'b1;
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(debug_control_zero, 32'h0);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    q.push_back(ID_VAL);
    jtag_tool_i.scan(1'b0, 32, $random(seed), 1'b1);
    repeat (4) @(negedge ref_clk);
    print_verdict;
  end
endmodule

bind debug_command_register_access dbg_cmd_sva dbg_cmd_sva_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tap_select_line(tap_select_line),
  .tdo(tdo), .tdo_en(tdo_en), .debug_mode(debug_mode), .step_pulse(step_pulse),
  .resume_pulse(resume_pulse), .debug_control_zero(debug_control_zero),
  .sw_update_block(sw_update_block), .nexus_path_sel(nexus_path_sel),
  .emul_enable_sel(emul_enable_sel));

`default_nettype wire
